// file: hw/vic_defs.svh
// Register offsets, field positions, reset values and timing counts of the interrupt controller.
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH
`define VIC_OFF_FLAGS0   8'h00
`define VIC_OFF_FLAGS1   8'h04
`define VIC_OFF_FLAGS2   8'h08
`define VIC_OFF_EN0      8'h0c
`define VIC_OFF_EN1      8'h10
`define VIC_OFF_EN2      8'h14
`define VIC_OFF_CTRL     8'h18
`define VIC_OFF_PVEC     8'h1c
`define VIC_OFF_CVEC     8'h20
`define VIC_CTRL_ACK0    0
`define VIC_CTRL_ACK1    1
`define VIC_CTRL_VOS     2
`define VIC_CTRL_IPC     3
`define VIC_RST_CTRL     4'h0
`define VIC_RST_PVEC     8'h00
`define VIC_RST_CVEC_HI  2'h0
`define VIC_NUM_SRC      20
`define VIC_NUM_SCU      8
`define VIC_NUM_DMA      8
`define VIC_NUM_TMR      4
`define VIC_NO_CODE      6'h3f
`define VIC_RESET_CYCLES 6
`endif

// file: hw/vic_pkg.sv
// Types shared by the interrupt controller.
package vic_pkg;
	typedef enum logic [1:0] {
		VIC_ACK_NONE   = 2'h0,
		VIC_ACK_SINGLE = 2'h1,
		VIC_ACK_DOUBLE = 2'h2,
		VIC_ACK_RSVD   = 2'h3
	} vic_ack_t;
	typedef enum logic [1:0] {
		VIC_IDLE,
		VIC_WAIT_SECOND,
		VIC_DRIVE
	} vic_state_t;
endpackage : vic_pkg

// file: hw/vic_top.sv
// Vectored interrupt controller with an AHB-Lite register slave.
//
// What this block does
// [R1] Twenty source flags in three status registers.
// [R2] Per-flag enable bits mask interrupt requests.
// [R3] Originating units raise their own flags.
// [R4] Any enabled active source asserts irq_n low.
// [R5] Host acknowledge starts a vector-driving cycle.
// [R6] Two control bits pick none, single, double.
// [R7] No-acknowledge style drives no vector.
// [R8] Single style drives vector on first acknowledge.
// [R9] Double style drives vector on second acknowledge.
// [R10] Select bit picks plain or coded vector.
// [R11] Plain vector register output unchanged.
// [R12] Coded vector: software top two, hardware six.
// [R13] Code names highest priority active source.
// [R14] Priority bit swaps serial and DMA priority.
// [R15] Reset input low six cycles resets everything.
// [R16] Request held while any enabled flag set.
// [R17] Source code latched for whole acknowledge cycle.
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "vic_defs.svh"
module vic_top (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [7:0]  scu_events,
	input  wire logic [7:0]  dma_events,
	input  wire logic [3:0]  tmr_events,
	output logic             irq_n,
	output logic             irq,
	input  wire logic        irq_ack_n,
	output logic [7:0]       vec_out,
	output logic             vec_oe
);

////////////////////////////////////////////////////////////////////////////////

	logic [19:0]             flags;
	logic [19:0]             enables;
	logic [3:0]              ctrl;
	logic [7:0]              plain_vector_reg;
	logic [1:0]              coded_hi;
	logic [5:0]              live_code;
	logic [19:0]             events;
	logic [19:0]             rd_clear;
	logic                    wr_pend;
	logic [7:0]              wr_addr;
	logic                    ack_prev;
	logic                    ack_fall;
	logic [7:0]              next_vec;
	vic_pkg::vic_state_t     state;
	vic_pkg::vic_ack_t       ack_type;

	// No wait states and no error answers: every register responds in one data phase.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign events    = {tmr_events, dma_events, scu_events}; // [R3]
	assign ack_type  = vic_pkg::vic_ack_t'({ctrl[`VIC_CTRL_ACK1], ctrl[`VIC_CTRL_ACK0]}); // [R6]
	assign ack_fall  = ack_prev & ~irq_ack_n;

////////////////////////////////////////////////////////////////////////////////
// Register bus.

	// Reads are decoded in the address phase so that hrdata stands for the whole data phase.
	logic rd_take;
	assign rd_take = hsel & hready & htrans[1] & ~hwrite;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend <= hsel & htrans[1] & hwrite;
			wr_addr <= haddr;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
		begin
			if (haddr == `VIC_OFF_FLAGS0)
				hrdata <= {24'h000000, flags[7:0]};
			else if (haddr == `VIC_OFF_FLAGS1)
				hrdata <= {24'h000000, flags[15:8]};
			else if (haddr == `VIC_OFF_FLAGS2)
				hrdata <= {28'h0000000, flags[19:16]};
			else if (haddr == `VIC_OFF_EN0)
				hrdata <= {24'h000000, enables[7:0]};
			else if (haddr == `VIC_OFF_EN1)
				hrdata <= {24'h000000, enables[15:8]};
			else if (haddr == `VIC_OFF_EN2)
				hrdata <= {28'h0000000, enables[19:16]};
			else if (haddr == `VIC_OFF_CTRL)
				hrdata <= {28'h0000000, ctrl};
			else if (haddr == `VIC_OFF_PVEC)
				hrdata <= {24'h000000, plain_vector_reg};
			else if (haddr == `VIC_OFF_CVEC)
				hrdata <= {24'h000000, coded_hi, live_code}; // [R12]
			else
				hrdata <= 32'h0000_0000;
		end
	end

	// A read of a status register clears the flags it returned.
	always_comb
	begin
		rd_clear = 20'h00000;
		if (rd_take && haddr == `VIC_OFF_FLAGS0)
			rd_clear[7:0] = 8'hff;
		else if (rd_take && haddr == `VIC_OFF_FLAGS1)
			rd_clear[15:8] = 8'hff;
		else if (rd_take && haddr == `VIC_OFF_FLAGS2)
			rd_clear[19:16] = 4'hf;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn) // [R15]
		begin
			enables          <= 20'h00000;
			ctrl             <= `VIC_RST_CTRL;
			plain_vector_reg <= `VIC_RST_PVEC;
			coded_hi         <= `VIC_RST_CVEC_HI;
		end
		else if (wr_pend)
		begin
			if (wr_addr == `VIC_OFF_EN0)
				enables[7:0] <= hwdata[7:0];
			else if (wr_addr == `VIC_OFF_EN1)
				enables[15:8] <= hwdata[7:0];
			else if (wr_addr == `VIC_OFF_EN2)
				enables[19:16] <= hwdata[3:0];
			else if (wr_addr == `VIC_OFF_CTRL)
				ctrl <= hwdata[3:0];
			else if (wr_addr == `VIC_OFF_PVEC)
				plain_vector_reg <= hwdata[7:0]; // [R11]
			else if (wr_addr == `VIC_OFF_CVEC)
				coded_hi <= hwdata[7:6]; // [R12]
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Source flags and request.

	// The event wins over a read clear in the same cycle so no event is lost.
	genvar gi;
	generate
		for (gi = 0; gi < `VIC_NUM_SRC; gi = gi + 1)
		begin : g_flag
			always_ff @(posedge clk)
			begin
				if (!rstn)
					flags[gi] <= 1'b0;
				else if (events[gi])
					flags[gi] <= 1'b1; // [R1]
				else if (rd_clear[gi])
					flags[gi] <= 1'b0;
			end
		end
	endgenerate

	logic [19:0] active;
	assign active = flags & enables; // [R2]
	assign irq_n  = ~|active; // [R4] [R16]
	assign irq    = |active;

////////////////////////////////////////////////////////////////////////////////
// Source code, highest priority first.

	// Within a unit the lowest index wins; timers always rank last.
	function automatic logic [5:0] vic_pick(input logic [19:0] act, input logic dma_first);
		logic [5:0] code;
		code = `VIC_NO_CODE;
		for (int i = `VIC_NUM_SRC - 1; i >= 16; i--)
			if (act[i])
				code = 6'(i);
		for (int i = 7; i >= 0; i--)
			if (dma_first ? act[i] : act[i + 8])
				code = dma_first ? 6'(i) : 6'(i + 8);
		for (int i = 7; i >= 0; i--)
			if (dma_first ? act[i + 8] : act[i])
				code = dma_first ? 6'(i + 8) : 6'(i);
		return code;
	endfunction : vic_pick

	assign live_code = vic_pick(active, ctrl[`VIC_CTRL_IPC]); // [R13] [R14]

////////////////////////////////////////////////////////////////////////////////
// Acknowledge cycle.

	always_comb
	begin
		if (ctrl[`VIC_CTRL_VOS])
			next_vec = {coded_hi, live_code}; // [R10]
		else
			next_vec = plain_vector_reg;
	end

	// Starting high matches the idle level of the acknowledge pin, so leaving reset
	// never looks like an acknowledge edge.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			ack_prev <= 1'b1;
		else
			ack_prev <= irq_ack_n;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			state <= vic_pkg::VIC_IDLE;
		else
		begin
			// A reserved acknowledge type is treated as none and leaves the machine idle.
			case (state)
				vic_pkg::VIC_IDLE:
					if (ack_fall && ack_type == vic_pkg::VIC_ACK_SINGLE)
						state <= vic_pkg::VIC_DRIVE; // [R8]
					else if (ack_fall && ack_type == vic_pkg::VIC_ACK_DOUBLE)
						state <= vic_pkg::VIC_WAIT_SECOND; // [R9]
				vic_pkg::VIC_WAIT_SECOND:
					if (ack_fall)
						state <= vic_pkg::VIC_DRIVE; // [R9]
				vic_pkg::VIC_DRIVE:
					if (irq_ack_n)
						state <= vic_pkg::VIC_IDLE;
				default:
					state <= vic_pkg::VIC_IDLE;
			endcase
		end
	end

	// The vector is frozen when driving starts so a new event cannot change it mid-cycle.
	always_ff @(posedge clk)
	begin
		if (!rstn)
			vec_out <= 8'h00;
		else if (ack_fall && (state == vic_pkg::VIC_WAIT_SECOND
			|| (state == vic_pkg::VIC_IDLE && ack_type == vic_pkg::VIC_ACK_SINGLE)))
			vec_out <= next_vec; // [R5] [R17]
	end

	// Nothing drives in the none style because the machine never leaves idle.
	assign vec_oe = (state == vic_pkg::VIC_DRIVE) & ~irq_ack_n; // [R7]

////////////////////////////////////////////////////////////////////////////////
// Checks.

	// A register write lands one edge after its address phase, so checks that expect
	// the mask to hold exclude a pending write rather than looking at the mask itself.

	a_irq_follows_enabled: assert property (@(posedge clk) disable iff (!rstn) // [R4]
		irq_n == !(|(flags & enables)))
		else $error("irq_n disagrees with enabled flags");

	a_irq_pair: assert property (@(posedge clk) disable iff (!rstn) // [R4]
		irq == !irq_n)
		else $error("irq and irq_n disagree");

	a_irq_held_set: assert property (@(posedge clk) disable iff (!rstn) // [R16]
		(!irq_n && !(|rd_clear) && !wr_pend) |=> !irq_n)
		else $error("irq dropped");

	a_irq_stays_off: assert property (@(posedge clk) disable iff (!rstn) // [R16]
		(irq_n && !(|events) && !wr_pend) |=> irq_n)
		else $error("irq raised without a source");

	a_event_sets_flag: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		(|events) |=> ((flags & $past(events)) == $past(events)))
		else $error("event flag not set");

	a_flag_read_clear: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		(rd_clear[0] && !events[0]) |=> !flags[0])
		else $error("flag not cleared by read");

	a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		!(|rd_clear) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag dropped without a read");

	a_mask_blocks: assert property (@(posedge clk) disable iff (!rstn) // [R2]
		(enables == 20'h00000) |-> irq_n)
		else $error("masked source requested");

	a_oe_after_ack: assert property (@(posedge clk) disable iff (!rstn) // [R5]
		$rose(vec_oe) |-> $past(ack_fall))
		else $error("vector driven without acknowledge");

	a_none_no_vec: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		(state == vic_pkg::VIC_IDLE && ack_type == vic_pkg::VIC_ACK_NONE && ack_fall)
		|=> !vec_oe)
		else $error("vector driven in none style");

	a_single_first: assert property (@(posedge clk) disable iff (!rstn) // [R8]
		(state == vic_pkg::VIC_IDLE && ack_type == vic_pkg::VIC_ACK_SINGLE && ack_fall)
		##1 !irq_ack_n |-> vec_oe)
		else $error("single missed");

	a_double_second: assert property (@(posedge clk) disable iff (!rstn) // [R9]
		(state == vic_pkg::VIC_IDLE && ack_type == vic_pkg::VIC_ACK_DOUBLE && ack_fall)
		|=> !vec_oe)
		else $error("double drove on first");

	a_vec_stable: assert property (@(posedge clk) disable iff (!rstn) // [R17]
		(vec_oe && $past(vec_oe)) |-> $stable(vec_out))
		else $error("vector moved");

	a_plain_vec: assert property (@(posedge clk) disable iff (!rstn) // [R10] [R11]
		(ack_fall && state == vic_pkg::VIC_WAIT_SECOND && !ctrl[`VIC_CTRL_VOS])
		|=> vec_out == $past(plain_vector_reg))
		else $error("plain vector wrong");

	a_coded_vec: assert property (@(posedge clk) disable iff (!rstn) // [R10] [R12]
		(ack_fall && state == vic_pkg::VIC_IDLE && ack_type == vic_pkg::VIC_ACK_SINGLE
		&& ctrl[`VIC_CTRL_VOS]) |=> vec_out == {$past(coded_hi), $past(live_code)})
		else $error("coded vector wrong");

	a_code_top: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		(active[0] && !ctrl[`VIC_CTRL_IPC]) |-> live_code == 6'h00)
		else $error("code rank");

	a_code_empty: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		!(|active) |-> live_code == `VIC_NO_CODE)
		else $error("code given with no active source");

	a_tmr_last: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		(|active[15:0]) |-> live_code < 6'h10)
		else $error("timer ranked above serial or dma");

	a_code_swap: assert property (@(posedge clk) disable iff (!rstn) // [R14]
		(active[8] && active[0] && ctrl[`VIC_CTRL_IPC]) |-> live_code == 6'h08)
		else $error("priority swap failed");

endmodule : vic_top
`default_nettype wire

// file: sim/vic_host_model.sv
// Host processor model that drives acknowledge assertions when the testbench calls its ack task.
`timescale 1ns/100ps
`default_nettype none
module vic_host_model (
	input  wire logic       clk,
	input  wire logic       vec_oe,
	input  wire logic [7:0] vec_out,
	output logic            irq_ack_n
);
	////////////////////////////////////////////////////////////////////////////////
	initial irq_ack_n = 1'b1;
	// Each assertion lasts three cycles and is followed by two released cycles.
	task automatic ack(input int n, output logic early, output logic oe, output logic [7:0] v);
		early = 1'b0;
		for (int k = 0; k < n; k++)
		begin
			irq_ack_n <= 1'b0;
			repeat (3) @(posedge clk);
			if (k < n - 1)
				early = early | vec_oe;
			oe = vec_oe;
			v = vec_out;
			irq_ack_n <= 1'b1;
			repeat (2) @(posedge clk);
		end
	endtask : ack
endmodule : vic_host_model
`default_nettype wire

// file: sim/vic_top_tb.sv
// Self-checking testbench of the interrupt controller.
`timescale 1ns/100ps
`default_nettype none
`include "vic_defs.svh"
module vic_top_tb;
	logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0]  haddr = 8'h00, scu_events = 8'h00, dma_events = 8'h00, vec_out;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic [3:0]  tmr_events = 4'h0;
	logic        hreadyout, hresp, irq_n, irq, irq_ack_n, vec_oe;
	logic [19:0] mf = 20'h0;
	int          bad_count = 0, compares = 0, cycles = 0;
	////////////////////////////////////////////////////////////////////////////////
	always #25 clk = ~clk;
	vic_top vic_top_i (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scu_events(scu_events),
		.dma_events(dma_events), .tmr_events(tmr_events), .irq_n(irq_n), .irq(irq),
		.irq_ack_n(irq_ack_n), .vec_out(vec_out), .vec_oe(vec_oe));
	vic_host_model host_i (.clk(clk), .vec_oe(vec_oe), .vec_out(vec_out), .irq_ack_n(irq_ack_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	// The model ranks enabled flags only, so masked sources never win the code.
	function automatic logic [5:0] top_code(input logic [19:0] f, input logic swap);
		int j;
		for (int i = 0; i < 20; i++)
		begin
			j = (swap && i < 16) ? (i + 8) % 16 : i;
			if (f[j])
				return 6'(j);
		end
		return `VIC_NO_CODE;
	endfunction : top_code
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			bad_count++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] rd;
		logic [19:0] ev, en;
		logic [3:0]  ctl;
		logic [7:0]  pv, v, xv;
		logic        early, oe, xoe;
		void'($urandom(4));
		repeat (16) @(posedge clk);
		chk("irq_n_in_reset", irq_n, 1'b1);
		chk("vec_oe_in_reset", vec_oe, 1'b0);
		chk("vec_out_in_reset", vec_out, 8'h00);
		chk("hrdata_in_reset", hrdata, 32'h0);
		chk("hresp_in_reset", hresp, 1'b0);
		rstn <= 1'b1;
		@(posedge clk);
		bus(1'b0, `VIC_OFF_CTRL, 32'h0, rd);
		chk("ctrl_reset", rd, 32'(`VIC_RST_CTRL));
		bus(1'b0, 8'h3c, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		$display("test reset done");
		for (int t = 0; t < 24; t++)
		begin
			en = 20'($urandom);
			ev = 20'($urandom & $urandom & $urandom);
			ctl = 4'($urandom);
			pv = 8'($urandom);
			for (int r = 0; r < 3; r++)
				bus(1'b1, `VIC_OFF_EN0 + 8'(4 * r), {24'h0, 8'(en >> (8 * r))}, rd);
			bus(1'b1, `VIC_OFF_CTRL, {28'h0, ctl}, rd);
			bus(1'b1, `VIC_OFF_PVEC, {24'h0, pv}, rd);
			bus(1'b1, `VIC_OFF_CVEC, {24'h0, pv}, rd);
			{tmr_events, dma_events, scu_events} <= ev;
			@(posedge clk);
			{tmr_events, dma_events, scu_events} <= 20'h0;
			@(posedge clk);
			mf = mf | ev;
			chk("irq_n", irq_n, ~|(mf & en));
			chk("irq", irq, |(mf & en));
			bus(1'b0, `VIC_OFF_CVEC, 32'h0, rd);
			chk("coded_vec", rd, {24'h0, pv[7:6], top_code(mf & en, ctl[3])});
			xoe = (ctl[1:0] == 2'h1) || (ctl[1:0] == 2'h2);
			xv = ctl[2] ? {pv[7:6], top_code(mf & en, ctl[3])} : pv;
			host_i.ack((ctl[1:0] == 2'h2) ? 2 : 1, early, oe, v);
			chk("first_ack_oe", early, 1'b0);
			chk("vec_oe", oe, xoe);
			if (xoe)
				chk("vector", v, xv);
			for (int r = 0; r < 3; r++)
			begin
				bus(1'b0, `VIC_OFF_FLAGS0 + 8'(4 * r), 32'h0, rd);
				chk("flags", rd, {24'h0, 8'(mf >> (8 * r))});
			end
			mf = 20'h0;
			chk("irq_n_cleared", irq_n, 1'b1);
			$display("test ack round %0d done", t);
		end
		bus(1'b1, `VIC_OFF_EN0, 32'h0000_00ff, rd);
		bus(1'b1, `VIC_OFF_CTRL, 32'h0000_000f, rd);
		scu_events <= 8'h01;
		@(posedge clk);
		scu_events <= 8'h00;
		@(posedge clk);
		chk("irq_n_before_reset", irq_n, 1'b0);
		rstn <= 1'b0;
		repeat (`VIC_RESET_CYCLES) @(posedge clk);
		chk("irq_n_mid_reset", irq_n, 1'b1);
		rstn <= 1'b1;
		@(posedge clk);
		bus(1'b0, `VIC_OFF_CTRL, 32'h0, rd);
		chk("ctrl_after_reset", rd, 32'(`VIC_RST_CTRL));
		bus(1'b0, `VIC_OFF_EN0, 32'h0, rd);
		chk("enables_after_reset", rd, 32'h0);
		bus(1'b0, `VIC_OFF_FLAGS0, 32'h0, rd);
		chk("flags_after_reset", rd, 32'h0);
		$display("test mid-run reset done");
		close_out();
	end
endmodule : vic_top_tb
`default_nettype wire
